// [core/amp_fault_pkg.sv]
// Purpose: Shared constants for the amplifier fault manager
// Assumes: 250 MHz ref_clk, AHB-Lite register access
// Notes:   Byte offsets, status bit positions, timing counts
package amp_fault_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_STATUS  = 8'h00;
    localparam logic [7:0] OFF_MASK    = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_LIVE    = 8'h0c;
    localparam logic [7:0] OFF_STATE   = 8'h10;
    // Error bit positions
    localparam int BIT_OV   = 0;
    localparam int BIT_UV   = 1;
    localparam int BIT_CLK  = 2;
    localparam int BIT_OC   = 3;
    localparam int BIT_DC   = 4;
    localparam int BIT_OT   = 5;
    localparam int NUM_ERR  = 6;
    // Control bits
    localparam int CTL_SHUTDOWN_N = 0;
    // Reset values
    localparam logic [5:0] MASK_RESET    = 6'h00;
    localparam logic       CONTROL_RESET = 1'b1;
    // Timing
    localparam int CLK_MHZ         = 250;
    localparam int DC_TIME_MS      = 420;
    localparam int DC_CYCLES       = DC_TIME_MS * 1000 * CLK_MHZ;
    localparam int DC_DUTY_PCT     = 60;
    localparam int FAULT_TIMEOUT_CYCLES = 1000;
    // Fault state machine
    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_LATCHED = 3'b010,
        ST_WAIT    = 3'b100
    } fault_state_t;
endpackage : amp_fault_pkg

// [core/dc_offset_detect.sv]
// Purpose: Per-channel DC detect on output duty cycle
// Assumes: duty_beyond says duty beyond limit, polarity gives its sign
// Notes:   Counter restarts on polarity change
`timescale 1ns/1ps
`default_nettype none
module dc_offset_detect #(
    parameter int DC_CYCLES = amp_fault_pkg::DC_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // Channel duty status
    input  wire logic duty_beyond,
    input  wire logic polarity,
    // Result
    output logic      dc_found
);
    logic [31:0] count;
    logic        last_pol;

    // Same polarity beyond the limit for longer than the window
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count    <= 32'h0000_0000;
            last_pol <= 1'b0;
            dc_found <= 1'b0;
        end else begin
            last_pol <= polarity;
            if (!duty_beyond || polarity != last_pol) begin
                count    <= 32'h0000_0000;
                dc_found <= 1'b0;
            end else if (count > 32'(DC_CYCLES)) begin
                dc_found <= 1'b1;
            end else begin
                count <= count + 32'h0000_0001;
            end
        end
    end
endmodule : dc_offset_detect
`default_nettype wire

// [core/amp_fault_manager.sv]
// Purpose: Fault handling for a stereo class-D amplifier
// Assumes: Detector inputs synchronous to ref_clk
// Notes:   AHB-Lite slave, zero wait states
// How it works
// - Every error sets its status bit; all but overvoltage and undervoltage pull fault low.
// - Overcurrent latches; playback stops until timeout and shutdown toggle.
// - DC offset latches; cleared only after timeout and shutdown toggle.
// - Overtemp latches; needs timeout, toggle and temperature below hysteresis.
// - Latching error still present at shutdown release re-enters fault.
// - Restart after latching error waits for toggle and timeout.
// - Non-latching errors recover alone with no toggle.
// - Only clock error among non-latching ones drives fault low.
// - Overvoltage flags non-latching, no fault output.
// - Undervoltage flags non-latching, no fault output.
// - Clock error on bad ratios, rates or stopped clocks.
// - Clock error clearing resumes playback and releases fault at once.
// - Latching fault output stays low until playback resumes.
// - Fault output is open-drain, low when asserted, else released.
// - DC error when duty beyond 60 percent, same polarity, over 420 ms.
// - Low shutdown input or bit shuts down; high releases.
`timescale 1ns/1ps
`default_nettype none
module amp_fault_manager #(
    parameter int DC_CYCLES     = amp_fault_pkg::DC_CYCLES,
    parameter int FAULT_TIMEOUT = amp_fault_pkg::FAULT_TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Analog detector levels
    input  wire logic        supply_above_ov,
    input  wire logic        supply_below_uv,
    input  wire logic        current_over,
    input  wire logic        temp_over,
    input  wire logic        temp_above_hyst,
    // Clock monitor
    input  wire logic        ratio_bad,
    input  wire logic        rate_bad,
    input  wire logic        clock_stopped,
    // Output duty monitors
    input  wire logic        left_duty_beyond,
    input  wire logic        left_polarity,
    input  wire logic        right_duty_beyond,
    input  wire logic        right_polarity,
    // Shutdown pin
    input  wire logic        amp_shutdown_n,
    // Fault open-drain pin
    output logic             fault_out_n,
    output logic             fault_out_oe,
    // Playback gate and interrupt
    output logic             play_enable,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    logic                        left_dc;
    logic                        right_dc;
    logic [amp_fault_pkg::NUM_ERR-1:0] err_now;
    logic [amp_fault_pkg::NUM_ERR-1:0] status;
    logic [amp_fault_pkg::NUM_ERR-1:0] mask;
    logic [amp_fault_pkg::NUM_ERR-1:0] w1c;
    logic                        shutdown_bit;
    logic                        shutdown_n;
    logic                        shutdown_n_q;
    logic                        toggled;
    logic                        latch_err;
    logic                        ot_still;
    logic                        over_temp_err;
    logic [31:0]                 timer;
    amp_fault_pkg::fault_state_t state;
    amp_fault_pkg::fault_state_t next_state;
    // Bus phase capture
    logic                        wr_pend;
    logic                        rd_pend;
    logic [7:0]                  addr_q;
    logic                        take;

    ////////////////////////////////////////////////////////////////////////
    // DC detectors per channel
    dc_offset_detect #(.DC_CYCLES(DC_CYCLES)) u_dc_left (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .duty_beyond (left_duty_beyond),
        .polarity    (left_polarity),
        .dc_found    (left_dc)
    );
    dc_offset_detect #(.DC_CYCLES(DC_CYCLES)) u_dc_right (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .duty_beyond (right_duty_beyond),
        .polarity    (right_polarity),
        .dc_found    (right_dc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live error conditions
    always_comb begin
        err_now = '0;
        err_now[amp_fault_pkg::BIT_OV]  = supply_above_ov;
        err_now[amp_fault_pkg::BIT_UV]  = supply_below_uv;
        err_now[amp_fault_pkg::BIT_CLK] = ratio_bad | rate_bad | clock_stopped;
        err_now[amp_fault_pkg::BIT_OC]  = current_over;
        err_now[amp_fault_pkg::BIT_DC]  = left_dc | right_dc;
        err_now[amp_fault_pkg::BIT_OT]  = over_temp_err;
    end

    // Overtemp stays asserted until die cools below hysteresis
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ot_still <= 1'b0;
        end else if (temp_over) begin
            ot_still <= 1'b1;
        end else if (!temp_above_hyst) begin
            ot_still <= 1'b0;
        end
    end
    assign over_temp_err = temp_over | ot_still;

    assign latch_err = err_now[amp_fault_pkg::BIT_OC] | err_now[amp_fault_pkg::BIT_DC]
                     | err_now[amp_fault_pkg::BIT_OT];

    ////////////////////////////////////////////////////////////////////////
    // Shutdown from pin and bit, both honoured
    assign shutdown_n = amp_shutdown_n & shutdown_bit;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            shutdown_n_q <= 1'b1;
        end else begin
            shutdown_n_q <= shutdown_n;
        end
    end

    // Toggle seen: shutdown went low while latched or waiting, held clear while in ST_RUN
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            toggled <= 1'b0;
        end else if (state == amp_fault_pkg::ST_RUN) begin
            toggled <= 1'b0;
        end else if (!shutdown_n) begin
            toggled <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latching fault state machine
    always_comb begin
        next_state = state;
        case (state)
            amp_fault_pkg::ST_RUN: begin
                if (latch_err) begin
                    next_state = amp_fault_pkg::ST_LATCHED;
                end
            end
            amp_fault_pkg::ST_LATCHED: begin
                // Release of shutdown after toggle, then timeout gate
                if (toggled && shutdown_n && !shutdown_n_q) begin
                    next_state = amp_fault_pkg::ST_WAIT;
                end
            end
            amp_fault_pkg::ST_WAIT: begin
                if (latch_err) begin
                    next_state = amp_fault_pkg::ST_LATCHED;
                end else if (timer >= 32'(FAULT_TIMEOUT) && shutdown_n) begin
                    next_state = amp_fault_pkg::ST_RUN;
                end else if (!shutdown_n) begin
                    next_state = amp_fault_pkg::ST_LATCHED;
                end
            end
            default: begin
                next_state = amp_fault_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state <= amp_fault_pkg::ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Timeout counter runs from fault entry, saturates at terminal count
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            timer <= 32'h0000_0000;
        end else if (state == amp_fault_pkg::ST_RUN) begin
            timer <= 32'h0000_0000;
        end else if (timer < 32'(FAULT_TIMEOUT)) begin
            timer <= timer + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Playback gate and fault pin
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            play_enable <= 1'b0;
            fault_out_oe <= 1'b0;
        end else begin
            // Non-latching errors gate playback only while present
            play_enable <= shutdown_n && next_state == amp_fault_pkg::ST_RUN
                        && !(|err_now);
            // Pulled low for any state other than ST_RUN (latched or wait) or clock error only
            fault_out_oe <= next_state != amp_fault_pkg::ST_RUN
                         || err_now[amp_fault_pkg::BIT_CLK];
        end
    end
    // Open drain: drives only a low level
    assign fault_out_n = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, set beats write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status <= '0;
        end else begin
            status <= (status & ~w1c) | err_now;
        end
    end
    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY
    assign take      = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
        end else begin
            wr_pend <= take & hwrite;
            rd_pend <= take & ~hwrite;
            addr_q  <= haddr[7:0];
        end
    end

    assign w1c = (wr_pend && addr_q == amp_fault_pkg::OFF_STATUS)
               ? hwdata[amp_fault_pkg::NUM_ERR-1:0] : '0;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mask         <= amp_fault_pkg::MASK_RESET;
            shutdown_bit <= amp_fault_pkg::CONTROL_RESET;
        end else if (wr_pend) begin
            if (addr_q == amp_fault_pkg::OFF_MASK) begin
                mask <= hwdata[amp_fault_pkg::NUM_ERR-1:0];
            end else if (addr_q == amp_fault_pkg::OFF_CONTROL) begin
                shutdown_bit <= hwdata[amp_fault_pkg::CTL_SHUTDOWN_N];
            end
        end
    end

    // Read data registered during address phase, valid in data phase
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            if (haddr[7:0] == amp_fault_pkg::OFF_STATUS) begin
                hrdata <= {26'h0, status};
            end else if (haddr[7:0] == amp_fault_pkg::OFF_MASK) begin
                hrdata <= {26'h0, mask};
            end else if (haddr[7:0] == amp_fault_pkg::OFF_CONTROL) begin
                hrdata <= {31'h0, shutdown_bit};
            end else if (haddr[7:0] == amp_fault_pkg::OFF_LIVE) begin
                hrdata <= {26'h0, err_now};
            end else if (haddr[7:0] == amp_fault_pkg::OFF_STATE) begin
                hrdata <= {27'h0, play_enable, toggled, state};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end
endmodule : amp_fault_manager
`default_nettype wire

// [bench/amp_fault_host.sv]
// Purpose: Host side of the fault and shutdown pins
// Assumes: Pull-up on the fault net
// Notes:   Shutdown level comes from the bench sequence
`timescale 1ns/1ps
`default_nettype none
module amp_fault_host (
    // Device pins
    input  wire logic fault_out_n,
    input  wire logic fault_out_oe,
    output logic      amp_shutdown_n,
    // Host view
    input  wire logic host_sd_n,
    output logic      fault_pin
);
    ////////////////////////////////////////////////////////////////
    // Released net reads the pull-up, never the last driven value
    assign fault_pin = fault_out_oe ? fault_out_n : 1'h1;
    // Host puts the amp down and back up to retry a recovery
    assign amp_shutdown_n = host_sd_n;
endmodule : amp_fault_host
`default_nettype wire

// [bench/amp_fault_manager_props.sv]
// Purpose: Port-level checks of the fault manager
// Assumes: Single ref_clk domain, sync reset
// Notes:   Timer check has two cycles of slack
`timescale 1ns/1ps
`default_nettype none
module amp_fault_props #(
    parameter int FAULT_TIMEOUT = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Detectors
    input wire logic supply_above_ov,
    input wire logic supply_below_uv,
    input wire logic current_over,
    input wire logic temp_over,
    input wire logic ratio_bad,
    input wire logic rate_bad,
    input wire logic clock_stopped,
    // Pins
    input wire logic amp_shutdown_n,
    input wire logic fault_out_n,
    input wire logic fault_out_oe,
    input wire logic play_enable
);
    logic        clk_any;
    logic        lat_in;
    logic        lat;
    logic        low_seen;
    logic        clk_run;
    logic [15:0] cnt;
    assign clk_any = ratio_bad | rate_bad | clock_stopped;
    assign lat_in  = current_over | temp_over;
    ////////////////////////////////////////////////////////////////
    // Cycles since the fault pin went active, saturating
    always_ff @(posedge ref_clk) begin
        if (!reset_n) cnt <= 16'h0;
        else if ($rose(fault_out_oe)) cnt <= 16'h1;
        else if (cnt != 16'hffff) cnt <= cnt + 16'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) lat <= 1'h0;
        else if (lat_in) lat <= 1'h1;
        else if (play_enable) lat <= 1'h0;
    end
    always_ff @(posedge ref_clk) begin
        if (!reset_n) low_seen <= 1'h0;
        else if ($rose(fault_out_oe)) low_seen <= 1'h0;
        else if (!amp_shutdown_n) low_seen <= 1'h1;
    end
    // Clock error that interrupted normal playback only
    always_ff @(posedge ref_clk) begin
        if (!reset_n) clk_run <= 1'h0;
        else clk_run <= clk_any && !lat_in && (clk_run || play_enable);
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    fault_level_a: assert property (fault_out_n == 1'h0)
        else $error("fault pin drive value not low");
    lat_fault_a: assert property (lat_in |=> fault_out_oe && !play_enable)
        else $error("latching error without fault");
    clk_fault_a: assert property (clk_any |=> fault_out_oe && !play_enable)
        else $error("clock error without fault");
    clk_clear_a: assert property ($fell(clk_any) && clk_run && !lat_in && !supply_above_ov
        && !supply_below_uv |=> !fault_out_oe && play_enable)
        else $error("clock error clear not immediate");
    oe_play_a: assert property (fault_out_oe |-> !play_enable)
        else $error("playback during fault");
    nl_hold_a: assert property ((supply_above_ov || supply_below_uv) && !fault_out_oe && !clk_any
        && !lat_in |=> !fault_out_oe && !play_enable)
        else $error("supply error handling wrong");
    nl_recover_a: assert property ($fell(supply_above_ov) && !supply_below_uv && !fault_out_oe
        && !clk_any && !lat_in && amp_shutdown_n |=> play_enable)
        else $error("no restart after supply error");
    lat_timer_a: assert property ($rose(play_enable) && lat |-> cnt >= FAULT_TIMEOUT - 2 && low_seen)
        else $error("latched restart too early");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
endmodule : amp_fault_props
bind amp_fault_manager amp_fault_props #(.FAULT_TIMEOUT(FAULT_TIMEOUT)) i_props (
    .ref_clk, .reset_n, .hreadyout, .hresp, .supply_above_ov, .supply_below_uv,
    .current_over, .temp_over, .ratio_bad, .rate_bad, .clock_stopped,
    .amp_shutdown_n, .fault_out_n, .fault_out_oe, .play_enable);
`default_nettype wire

// [bench/amp_fault_manager_bench.sv]
// Purpose: Self-checking bench for the fault manager
// Assumes: Zero wait bus slave, 250 MHz ref_clk
// Notes:   Timeout and DC window shortened by parameters
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module amp_fault_manager_bench;
    localparam int TMO = 16;
    localparam int DCW = 20;
    logic        ref_clk;
    logic        reset_n;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic        hreadyout;
    logic        hresp;
    logic [11:0] err;
    logic        host_sd_n;
    logic        amp_shutdown_n;
    logic        fault_out_n;
    logic        fault_out_oe;
    logic        fault_pin;
    logic        play_enable;
    logic        irq;
    int          errors;
    int          checked;
    amp_fault_manager #(.DC_CYCLES(DCW), .FAULT_TIMEOUT(TMO)) i_dut (
        .ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .supply_above_ov(err[0]), .supply_below_uv(err[1]), .ratio_bad(err[2]),
        .rate_bad(err[3]), .clock_stopped(err[4]), .current_over(err[5]),
        .temp_over(err[6]), .temp_above_hyst(err[7]), .left_duty_beyond(err[8]),
        .left_polarity(err[9]), .right_duty_beyond(err[10]), .right_polarity(err[11]),
        .amp_shutdown_n, .fault_out_n, .fault_out_oe, .play_enable, .irq);
    amp_fault_host i_host (.fault_out_n, .fault_out_oe, .amp_shutdown_n, .host_sd_n, .fault_pin);
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // Address phase held until ready, then data phase until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask : wr
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        bus(1'h0, a, 32'h0);
        `CHK(nm, ex, q)
    endtask : rd_chk
    task automatic sd(input logic v);
        @(posedge ref_clk);
        host_sd_n <= v;
        tick(2);
    endtask : sd
    task automatic pins(input logic p, input logic e);
        #1;
        `CHK("fault pin", p, fault_pin)
        `CHK("play", e, play_enable)
    endtask : pins
    task automatic irq_chk(input logic e);
        tick(2);
        #1;
        `CHK("irq", e, irq)
    endtask : irq_chk
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd_chk("status", amp_fault_pkg::OFF_STATUS, 32'h0);
        rd_chk("mask", amp_fault_pkg::OFF_MASK, 32'h0);
        rd_chk("control", amp_fault_pkg::OFF_CONTROL, 32'h1);
        rd_chk("unmapped", 8'h20, 32'h0);
        wr(amp_fault_pkg::OFF_MASK, 32'h3f);
        rd_chk("mask", amp_fault_pkg::OFF_MASK, 32'h3f);
        wr(amp_fault_pkg::OFF_MASK, 32'h0);
        sd(1'h0);
        pins(1'h1, 1'h0);
        sd(1'h1);
        pins(1'h1, 1'h1);
    endtask : t_regs
    task automatic t_nonlatch(input int i, input int b);
        @(posedge ref_clk);
        err[i] <= 1'h1;
        tick(4);
        pins(b != amp_fault_pkg::BIT_CLK, 1'h0);
        rd_chk("status", amp_fault_pkg::OFF_STATUS, 32'h1 << b);
        rd_chk("live", amp_fault_pkg::OFF_LIVE, 32'h1 << b);
        err[i] <= 1'h0;
        tick(4);
        pins(1'h1, 1'h1);
        wr(amp_fault_pkg::OFF_STATUS, 32'h3f);
    endtask : t_nonlatch
    // Retry with the error present, then a clean toggle
    task automatic t_latch(input int i, input int b);
        @(posedge ref_clk);
        err[i] <= 1'h1;
        err[7] <= (i == 6);
        tick(DCW + 8);
        pins(1'h0, 1'h0);
        rd_chk("status", amp_fault_pkg::OFF_STATUS, 32'h1 << b);
        rd_chk("state", amp_fault_pkg::OFF_STATE, 32'h2);
        sd(1'h0);
        sd(1'h1);
        tick(TMO + 4);
        pins(1'h0, 1'h0);
        @(posedge ref_clk);
        err[i] <= 1'h0;
        tick(TMO + 4);
        pins(1'h0, 1'h0);
        sd(1'h0);
        sd(1'h1);
        tick(TMO + 4);
        pins(i != 6, i != 6);
        @(posedge ref_clk);
        err[7] <= 1'h0;
        wr(amp_fault_pkg::OFF_CONTROL, 32'h0);
        wr(amp_fault_pkg::OFF_CONTROL, 32'h1);
        tick(TMO + 4);
        pins(1'h1, 1'h1);
        wr(amp_fault_pkg::OFF_STATUS, 32'h3f);
    endtask : t_latch
    task automatic t_timer();
        @(posedge ref_clk);
        err[8] <= 1'h1;
        tick(DCW / 2);
        err[8] <= 1'h0;
        tick(4);
        pins(1'h1, 1'h1);
        @(posedge ref_clk);
        err[5] <= 1'h1;
        tick(1);
        err[5] <= 1'h0;
        sd(1'h0);
        sd(1'h1);
        pins(1'h0, 1'h0);
        tick(TMO);
        pins(1'h1, 1'h1);
        wr(amp_fault_pkg::OFF_STATUS, 32'h3f);
    endtask : t_timer
    task automatic t_irq();
        wr(amp_fault_pkg::OFF_MASK, 32'h1 << amp_fault_pkg::BIT_UV);
        @(posedge ref_clk);
        err[1] <= 1'h1;
        tick(2);
        err[1] <= 1'h0;
        irq_chk(1'h1);
        wr(amp_fault_pkg::OFF_MASK, 32'h0);
        irq_chk(1'h0);
        wr(amp_fault_pkg::OFF_MASK, 32'h3f);
        irq_chk(1'h1);
        wr(amp_fault_pkg::OFF_STATUS, 32'h1 << amp_fault_pkg::BIT_UV);
        irq_chk(1'h0);
        rd_chk("status", amp_fault_pkg::OFF_STATUS, 32'h0);
    endtask : t_irq
    task automatic results();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        checked = 0;
        reset_n = 1'h0;
        hsize = 3'h2;
        host_sd_n = 1'h1;
        {hsel, hwrite, htrans, haddr, hwdata, err} = '0;
        tick(16);
        reset_n <= 1'h1;
        t_regs();
        for (int i = 0; i < 5; i++) begin
            t_nonlatch(i, (i < 2) ? i : amp_fault_pkg::BIT_CLK);
        end
        t_latch(5, amp_fault_pkg::BIT_OC);
        t_latch(8, amp_fault_pkg::BIT_DC);
        t_latch(6, amp_fault_pkg::BIT_OT);
        t_timer();
        t_irq();
        results();
    end
    // Hang guard, far beyond the several hundred cycles needed
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        results();
    end
endmodule : amp_fault_manager_bench
`default_nettype wire
